// ==== src/sbc_ctrl.sv ====
// Serial bus control and status register block with Avalon-MM slave

module sbc_ctrl
    import sbc_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // Avalon-MM slave
    input  wire logic [SBC_ADDR_W-1:0] avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic      [31:0]           avs_readdata_o,
    output logic                       avs_waitrequest_o,
    // Channel status from surrounding serial logic
    input  wire logic                  channel_enable_i,
    input  wire logic                  xfer_start_i,
    input  wire logic                  addr_mismatch_i,
    // Serial clock pin and open-drain data line
    input  wire logic                  serial_clock_pin_i,
    input  wire logic                  sb_i,
    output logic                       sb_o,
    output logic                       sb_oe_n_o,
    // Interrupt
    output logic                       irq_o
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisation and edge detection

    logic [1:0] pins_sync;
    logic       sck_s;
    logic       sda_s;
    logic       sck_prev;
    logic       sda_prev;
    logic       sck_fall;
    logic       sck_rise;
    logic       rel_seen;
    logic       cmd_seen;

    sbc_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({serial_clock_pin_i, sb_i}),
        .sync_o  (pins_sync)
    );

    assign sck_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sck_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            sck_prev <= sck_s;
            sda_prev <= sda_s;
        end
    end

    assign sck_fall = sck_prev & ~sck_s;
    assign sck_rise = ~sck_prev & sck_s;
    // Data edges while clock stays high
    assign rel_seen = sck_s & sck_prev & ~sda_prev & sda_s;
    assign cmd_seen = sck_s & sck_prev & sda_prev & ~sda_s;

    ////////////////////////////////////////////////////////////////////
    // Bus slave

    logic        resp_q;
    logic        access;
    logic        wr_csr;
    logic        wr_stat;
    logic        wr_mask;
    logic [7:0]  wdata;
    logic [31:0] next_rdata;

    // One wait cycle for every access
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~resp_q;
    assign access = (avs_read_i | avs_write_i) & resp_q;
    assign wdata  = avs_writedata_i[7:0];
    assign wr_csr = access & avs_write_i & avs_byteenable_i[0]
                    & (avs_address_i == SBC_ADDR_CSR);
    assign wr_stat = access & avs_write_i & avs_byteenable_i[0]
                     & (avs_address_i == SBC_ADDR_IRQ_STAT);
    assign wr_mask = access & avs_write_i & avs_byteenable_i[0]
                     & (avs_address_i == SBC_ADDR_IRQ_MASK);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            resp_q <= 1'b0;
        end else begin
            resp_q <= (avs_read_i | avs_write_i) & ~resp_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Writable control bits

    logic busy_sync_enable;
    logic ack_auto_enable;
    logic release_trigger;
    logic command_trigger;
    logic ack_trigger;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !channel_enable_i) begin
            busy_sync_enable <= SBC_CSR_RESET[SBC_BUSY_SYNC_EN];
            ack_auto_enable  <= SBC_CSR_RESET[SBC_ACK_AUTO_EN];
        end else if (wr_csr) begin
            busy_sync_enable <= wdata[SBC_BUSY_SYNC_EN];
            ack_auto_enable  <= wdata[SBC_ACK_AUTO_EN];
        end
    end

    // Triggers live one cycle, then clear themselves
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !channel_enable_i) begin
            release_trigger <= 1'b0;
            command_trigger <= 1'b0;
        end else begin
            release_trigger <= wr_csr & wdata[SBC_RELEASE_TRIGGER];
            command_trigger <= wr_csr & wdata[SBC_COMMAND_TRIGGER];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output latch

    logic so_latch;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !channel_enable_i) begin
            so_latch <= 1'b1;
        end else if (release_trigger) begin
            so_latch <= 1'b1;
        end else if (command_trigger) begin
            so_latch <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transfer progress: falling serial clock edges since start

    logic [3:0] fall_cnt;
    logic       xfer_done;
    logic       in_xfer;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !channel_enable_i) begin
            in_xfer  <= 1'b0;
            fall_cnt <= SBC_EDGE_MAX;
        end else if (xfer_start_i) begin
            in_xfer  <= 1'b1;
            fall_cnt <= 4'h0;
        end else if (sck_fall && fall_cnt != SBC_EDGE_MAX) begin
            fall_cnt <= fall_cnt + 4'h1;
        end
    end

    assign xfer_done = in_xfer & (fall_cnt >= SBC_XFER_EDGES);

    ////////////////////////////////////////////////////////////////////
    // Acknowledge generation

    logic ack_pending;
    logic ack_armed;
    logic ack_drive;
    logic ack_fire;
    logic auto_rise;

    assign auto_rise = wr_csr & wdata[SBC_ACK_AUTO_EN] & ~ack_auto_enable;

    // Pending ack waits for the next falling edge
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !channel_enable_i || xfer_start_i) begin
            ack_pending <= 1'b0;
        end else if (wr_csr && wdata[SBC_ACK_TRIGGER]) begin
            ack_pending <= 1'b1;
        end else if (auto_rise && xfer_done) begin
            ack_pending <= 1'b1;
        end else if (sck_fall) begin
            ack_pending <= 1'b0;
        end
    end

    // Auto-enable seen before completion arms the ninth-edge ack
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !channel_enable_i || xfer_start_i) begin
            ack_armed <= 1'b0;
        end else if (ack_auto_enable && in_xfer && !xfer_done) begin
            ack_armed <= 1'b1;
        end else if (sck_fall && fall_cnt == SBC_XFER_EDGES) begin
            ack_armed <= 1'b0;
        end
    end

    assign ack_fire = sck_fall & (ack_pending
                      | (ack_armed & ack_auto_enable
                         & fall_cnt == SBC_XFER_EDGES));

    // Ack held low for one serial clock period
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !channel_enable_i) begin
            ack_drive <= 1'b0;
        end else if (ack_fire) begin
            ack_drive <= 1'b1;
        end else if (sck_fall) begin
            ack_drive <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Busy signal after the acknowledge

    logic busy_drive;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !channel_enable_i || xfer_start_i) begin
            busy_drive <= 1'b0;
        end else if (sck_fall && ack_drive && busy_sync_enable) begin
            busy_drive <= 1'b1;
        end else if (sck_fall && !busy_sync_enable) begin
            busy_drive <= 1'b0;
        end
    end

    // Open drain: only ever pulls low
    assign sb_o      = 1'b0;
    assign sb_oe_n_o = ~(~so_latch | ack_drive | busy_drive);

    ////////////////////////////////////////////////////////////////////
    // Detection flags, read-only to software

    logic release_detected_flag;
    logic command_detected_flag;
    logic ack_detected_flag;
    logic ack_clr_wait;
    logic ack_seen;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !channel_enable_i) begin
            release_detected_flag <= 1'b0;
        end else if (rel_seen) begin
            release_detected_flag <= 1'b1;
        end else if (xfer_start_i || addr_mismatch_i) begin
            release_detected_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !channel_enable_i) begin
            command_detected_flag <= 1'b0;
        end else if (cmd_seen) begin
            command_detected_flag <= 1'b1;
        end else if (xfer_start_i || rel_seen) begin
            command_detected_flag <= 1'b0;
        end
    end

    // Ack flag clears at the first falling edge after a start
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !channel_enable_i) begin
            ack_clr_wait <= 1'b0;
        end else if (xfer_start_i) begin
            ack_clr_wait <= 1'b1;
        end else if (sck_fall) begin
            ack_clr_wait <= 1'b0;
        end
    end

    // Only the rise of the ninth clock carries the ack, not the last data bit
    assign ack_seen = sck_rise & in_xfer & (fall_cnt == SBC_ACK_EDGE)
                      & ~sda_s;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !channel_enable_i) begin
            ack_detected_flag <= 1'b0;
        end else if (ack_seen) begin
            ack_detected_flag <= 1'b1;
        end else if (ack_clr_wait && sck_fall) begin
            ack_detected_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    logic [SBC_IRQ_W-1:0] irq_stat;
    logic [SBC_IRQ_W-1:0] irq_mask;
    logic [SBC_IRQ_W-1:0] irq_set;
    logic [SBC_IRQ_W-1:0] irq_clr;

    assign irq_set = {ack_seen, cmd_seen, rel_seen};
    assign irq_clr = wr_stat ? wdata[SBC_IRQ_W-1:0] : '0;

    // Set wins over a simultaneous write-one clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_stat <= SBC_IRQ_RESET;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_mask <= SBC_IRQ_RESET;
        end else if (wr_mask) begin
            irq_mask <= wdata[SBC_IRQ_W-1:0];
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    ////////////////////////////////////////////////////////////////////
    // Read data

    logic [7:0] csr_value;

    always_comb begin
        csr_value = 8'h00;
        csr_value[SBC_RELEASE_DET]  = release_detected_flag;
        csr_value[SBC_COMMAND_DET]  = command_detected_flag;
        csr_value[SBC_ACK_AUTO_EN]  = ack_auto_enable;
        csr_value[SBC_ACK_DET]      = ack_detected_flag;
        csr_value[SBC_BUSY_SYNC_EN] = busy_sync_enable;
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (avs_address_i)
            SBC_ADDR_CSR:      next_rdata[7:0] = csr_value;
            SBC_ADDR_IRQ_STAT: next_rdata[SBC_IRQ_W-1:0] = irq_stat;
            SBC_ADDR_IRQ_MASK: next_rdata[SBC_IRQ_W-1:0] = irq_mask;
            default:           next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !resp_q) begin
            avs_readdata_o <= next_rdata;
        end
    end

endmodule

// ==== src/sbc_pkg.sv ====
// Constants for the serial bus control and status block
package sbc_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [15:0] SBC_IDX_CSR      = 16'hFF61;
    localparam logic [15:0] SBC_IDX_IRQ_STAT = 16'hFF70;
    localparam logic [15:0] SBC_IDX_IRQ_MASK = 16'hFF71;
    localparam int          SBC_ADDR_W       = 18;
    localparam logic [17:0] SBC_ADDR_CSR      = {SBC_IDX_CSR, 2'b00};
    localparam logic [17:0] SBC_ADDR_IRQ_STAT = {SBC_IDX_IRQ_STAT, 2'b00};
    localparam logic [17:0] SBC_ADDR_IRQ_MASK = {SBC_IDX_IRQ_MASK, 2'b00};

    // Control/status register field positions
    localparam int SBC_RELEASE_TRIGGER = 0;
    localparam int SBC_COMMAND_TRIGGER = 1;
    localparam int SBC_RELEASE_DET     = 2;
    localparam int SBC_COMMAND_DET     = 3;
    localparam int SBC_ACK_TRIGGER     = 4;
    localparam int SBC_ACK_AUTO_EN     = 5;
    localparam int SBC_ACK_DET         = 6;
    localparam int SBC_BUSY_SYNC_EN    = 7;

    // Interrupt status and mask field positions
    localparam int SBC_IRQ_RELEASE = 0;
    localparam int SBC_IRQ_COMMAND = 1;
    localparam int SBC_IRQ_ACK     = 2;
    localparam int SBC_IRQ_W       = 3;

    // Reset values
    localparam logic [7:0]  SBC_CSR_RESET = 8'h00;
    localparam logic [2:0]  SBC_IRQ_RESET = 3'h0;

    // Falling serial clock edges: data bits of a transfer, acknowledge edge
    localparam logic [3:0]  SBC_XFER_EDGES = 4'h8;
    localparam logic [3:0]  SBC_ACK_EDGE   = 4'h9;
    localparam logic [3:0]  SBC_EDGE_MAX   = 4'hF;

    // Synchroniser depth
    localparam int SBC_SYNC_STAGES = 2;

endpackage

// ==== src/sbc_sync.sv ====
// Two-flop synchroniser for pins from outside the clock domain
module sbc_sync
    import sbc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stage1 <= '1;
            stage2 <= '1;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
        end
    end

    assign sync_o = stage2;

endmodule

// ==== tb/sbc_ctrl_checker.sv ====
// Port-level assertions for the serial bus control block
module sbc_ctrl_checker
    import sbc_pkg::*;
(
    // Clock and reset
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    // Avalon-MM slave
    input wire logic [SBC_ADDR_W-1:0] avs_address_i,
    input wire logic                  avs_read_i,
    input wire logic                  avs_write_i,
    input wire logic [31:0]           avs_writedata_i,
    input wire logic [3:0]            avs_byteenable_i,
    input wire logic [31:0]           avs_readdata_o,
    input wire logic                  avs_waitrequest_o,
    // Channel status
    input wire logic                  channel_enable_i,
    input wire logic                  xfer_start_i,
    input wire logic                  addr_mismatch_i,
    // Serial pins and interrupt
    input wire logic                  serial_clock_pin_i,
    input wire logic                  sb_i,
    input wire logic                  sb_o,
    input wire logic                  sb_oe_n_o,
    input wire logic                  irq_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic wr_csr;
    logic rd_csr;
    assign wr_csr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                    && avs_address_i == SBC_ADDR_CSR && channel_enable_i;
    assign rd_csr = avs_read_i && !avs_waitrequest_o
                    && avs_address_i == SBC_ADDR_CSR;

    ////////////////////////////////////////////////////////////////////////
    AST_WAIT_FIRST: assert property (
        $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("no wait state in first request cycle");
    AST_WAIT_ONE: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o)
        else $error("wait state longer than one cycle");
    AST_IDLE_NOWAIT: assert property (
        !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest high while idle");
    AST_SB_ZERO: assert property (
        sb_o == 1'b0)
        else $error("data line driven high");
    AST_DIS_RELEASE: assert property (
        !channel_enable_i [*2] |-> sb_oe_n_o)
        else $error("line held low while channel off");
    AST_TRIG_READ_ZERO: assert property (
        rd_csr |-> avs_readdata_o[4] == 1'b0 && avs_readdata_o[1:0] == 2'b00)
        else $error("trigger bit read back as one");
    AST_CMD_TRIG: assert property (
        wr_csr && avs_writedata_i[1:0] == 2'b10 && !avs_writedata_i[4]
        |-> ##[1:3] !sb_oe_n_o)
        else $error("command trigger did not pull line low");
    AST_REL_TRIG: assert property (
        wr_csr && avs_writedata_i[1:0] == 2'b01 && !avs_writedata_i[4]
        |-> ##[1:3] sb_oe_n_o)
        else $error("release trigger did not free line");

    cover property (wr_csr && avs_writedata_i[4]);
    cover property ($fell(sb_oe_n_o) && serial_clock_pin_i == 1'b0);
    cover property ($rose(irq_o));
endmodule

// ==== tb/sbc_far_end.sv ====
// Far-side bus device: drives serial clock and data, samples the ack
module sbc_far_end (
    // Serial clock and open-drain pull-down
    output logic      sck_o,
    output logic      low_o,
    // Wired line level and sampled ack
    input  wire logic line_i,
    output logic      ack_seen_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sck_o = 1'b1;
        low_o = 1'b0;
        ack_seen_o = 1'b0;
    end

    // Clock stands high between frames; data moves only while clock low
    // Clocks first to last-1 of a frame; clock 8 is the ack clock
    task automatic frame(input int first, input int last,
                         input logic [7:0] d);
        for (int i = first; i < last; i++) begin
            sck_o = 1'b0;
            #31.25;
            low_o = (i < 8) ? ~d[7-i] : 1'b0;
            #31.25;
            sck_o = 1'b1;
            if (i == 8) ack_seen_o = ~line_i;
            #62.5;
        end
    endtask

    // Data falls then rises while clock high
    task automatic bus_release();
        low_o = 1'b1;
        #100;
        low_o = 1'b0;
        #100;
    endtask
endmodule

// ==== tb/test_serial_bus_ctrl_status.sv ====
// Self-checking bench for the serial bus control and status block
module test_serial_bus_ctrl_status;
    import sbc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clk_i = 1'b0;
    logic                  rst_n_i = 1'b0;
    logic [SBC_ADDR_W-1:0] avs_address_i = '0;
    logic                  avs_read_i = 1'b0;
    logic                  avs_write_i = 1'b0;
    logic [31:0]           avs_writedata_i = '0;
    logic [3:0]            avs_byteenable_i = 4'hF;
    logic [31:0]           avs_readdata_o;
    logic                  avs_waitrequest_o;
    logic                  channel_enable_i = 1'b1;
    logic                  xfer_start_i = 1'b0;
    logic                  addr_mismatch_i = 1'b0;
    logic                  sck, far_low, sb_line, ack_seen;
    logic                  sb_o, sb_oe_n_o, irq_o;
    logic [7:0]            rnd = 8'h1B;
    logic [7:0]            rd, v;
    int                    num_errors = 0;
    int                    cmp_count = 0;

    always #4 clk_i = ~clk_i;
    assign sb_line = !(far_low || !sb_oe_n_o);

    sbc_ctrl sbc_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .channel_enable_i(channel_enable_i), .xfer_start_i(xfer_start_i),
        .addr_mismatch_i(addr_mismatch_i), .serial_clock_pin_i(sck),
        .sb_i(sb_line), .sb_o(sb_o), .sb_oe_n_o(sb_oe_n_o), .irq_o(irq_o));
    sbc_far_end sbc_far_end_inst (.sck_o(sck), .low_o(far_low),
        .line_i(sb_line), .ack_seen_o(ack_seen));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Only bits 5 and 7 keep written values; flags come from the line
    function automatic logic [7:0] exp_csr(input logic [7:0] w,
                                           input logic [7:0] f);
        return (w & 8'hA0) | (f & 8'h4C);
    endfunction

    task automatic print_verdict();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t register got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t pin got %b want %b", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [17:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        rd = avs_readdata_o[7:0];
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0) begin
            num_errors++;
            $display("ERROR %0t bus request never answered", $time);
            print_verdict();
        end
    endtask
    task automatic rdchk(input logic [17:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk8(rd, exp);
    endtask
    task automatic pulse(input logic mis);
        @(posedge clk_i);
        if (mis) addr_mismatch_i <= 1'b1;
        else xfer_start_i <= 1'b1;
        @(posedge clk_i);
        addr_mismatch_i <= 1'b0;
        xfer_start_i <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdchk(SBC_ADDR_CSR, SBC_CSR_RESET);
        rdchk(SBC_ADDR_IRQ_STAT, 8'h00);
        chk1(sb_oe_n_o, 1'b1);
        // Own command then release, seen back on the line
        bus(1'b1, SBC_ADDR_CSR, 8'h02);
        repeat (8) @(posedge clk_i);
        chk1(sb_oe_n_o, 1'b0);
        rdchk(SBC_ADDR_CSR, 8'h08);
        bus(1'b1, SBC_ADDR_CSR, 8'h01);
        repeat (8) @(posedge clk_i);
        chk1(sb_oe_n_o, 1'b1);
        rdchk(SBC_ADDR_CSR, 8'h04);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            v = rnd & 8'hEC;
            bus(1'b1, SBC_ADDR_CSR, v);
            rdchk(SBC_ADDR_CSR, exp_csr(v, 8'h04));
        end
        bus(1'b1, SBC_ADDR_CSR, 8'h00);
        pulse(1'b0);
        rdchk(SBC_ADDR_CSR, 8'h00);
        sbc_far_end_inst.bus_release();
        rdchk(SBC_ADDR_CSR, 8'h04);
        pulse(1'b1);
        rdchk(SBC_ADDR_CSR, 8'h00);
        // Channel off frees the line and clears the flags
        sbc_far_end_inst.bus_release();
        bus(1'b1, SBC_ADDR_CSR, 8'h02);
        @(posedge clk_i);
        channel_enable_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk1(sb_oe_n_o, 1'b1);
        channel_enable_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rdchk(SBC_ADDR_CSR, 8'h00);
        // Ack modes: none, early auto, trigger, late auto
        for (int m = 0; m < 4; m++) begin
            pulse(1'b0);
            if (m == 1) bus(1'b1, SBC_ADDR_CSR, 8'h20);
            rnd = lfsr(rnd);
            sbc_far_end_inst.frame(0, 8, rnd);
            if (m == 2) bus(1'b1, SBC_ADDR_CSR, 8'h10);
            if (m == 3) bus(1'b1, SBC_ADDR_CSR, 8'hA0);
            sbc_far_end_inst.frame(8, 10, 8'h00);
            chk1(ack_seen, m != 0);
            repeat (4) @(posedge clk_i);
            // Last mode also holds the line with the busy signal
            chk1(sb_oe_n_o, m != 3);
            v = m == 0 ? 8'h00 : m == 1 ? 8'h60 : m == 2 ? 8'h40 : 8'hE0;
            rdchk(SBC_ADDR_CSR, v);
            bus(1'b1, SBC_ADDR_CSR, 8'h00);
        end
        // Interrupt: sticky status, mask, write-one clear
        rdchk(SBC_ADDR_IRQ_STAT, 8'h07);
        chk1(irq_o, 1'b0);
        bus(1'b1, SBC_ADDR_IRQ_MASK, 8'h04);
        repeat (2) @(posedge clk_i);
        chk1(irq_o, 1'b1);
        bus(1'b1, SBC_ADDR_IRQ_STAT, 8'h07);
        repeat (2) @(posedge clk_i);
        chk1(irq_o, 1'b0);
        rdchk(SBC_ADDR_IRQ_STAT, 8'h00);
        bus(1'b1, 18'h00010, 8'hFF);
        rdchk(18'h00010, 8'h00);
        print_verdict();
    end

    initial begin
        #200000;
        num_errors++;
        $display("ERROR %0t run did not finish", $time);
        print_verdict();
    end
endmodule

bind sbc_ctrl sbc_ctrl_checker sbc_ctrl_checker_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .channel_enable_i(channel_enable_i), .xfer_start_i(xfer_start_i),
    .addr_mismatch_i(addr_mismatch_i),
    .serial_clock_pin_i(serial_clock_pin_i), .sb_i(sb_i), .sb_o(sb_o),
    .sb_oe_n_o(sb_oe_n_o), .irq_o(irq_o));
